// file: mmc_pkg.sv
package mmc_pkg;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [11:0] MMC_IDX_MODE      = 12'h000;
  localparam logic [11:0] MMC_IDX_STATUS    = 12'h004;
  localparam logic [11:0] MMC_IDX_CAL       = 12'h008;
  localparam logic [11:0] MMC_IDX_WINDOW    = 12'h00a;
  localparam logic [11:0] MMC_IDX_IRQ_STAT  = 12'h010;
  localparam logic [11:0] MMC_IDX_IRQ_MASK  = 12'h012;
  localparam int          MMC_ADDR_W        = 14;

  // Mode register fields
  localparam int          MMC_MODE_NOLOAD   = 0;
  localparam int          MMC_MODE_PHASE    = 1;
  localparam int          MMC_MODE_POSONLY  = 2;
  localparam int          MMC_MODE_ENA_LSB  = 3;
  localparam logic [15:0] MMC_MODE_WMASK    = 16'hf8ff;
  localparam logic [15:0] MMC_MODE_RESET    = 16'h0000;

  // Status and calibration control fields
  localparam int          MMC_STAT_NEG      = 2;
  localparam int          MMC_CAL_MODE      = 0;
  localparam int          MMC_CAL_UPDATE    = 1;

  // Window exponent
  localparam logic [15:0] MMC_WIN_RESET     = 16'h0000;
  localparam logic [3:0]  MMC_WIN_MAX_EXP   = 4'h8;
  localparam int          MMC_CNT_W         = 9;

  // Interrupt bits
  localparam int          MMC_IRQ_DONE      = 0;
  localparam int          MMC_IRQ_NEG       = 1;
  localparam int          MMC_IRQ_W         = 2;

  localparam logic [1:0]  MMC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  MMC_RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    MMC_WIN_IDLE  = 2'b00,
    MMC_WIN_ARMED = 2'b01,
    MMC_WIN_RUN   = 2'b10
  } mmc_win_e;

  typedef struct packed {
    logic [2:0] phase_accumulate_enable;
    logic       positive_only;
    logic       single_point_phase;
    logic       no_load_threshold_enable;
  } mmc_mode_s;

  typedef struct packed {
    logic       cal_mode;
    logic       use_cal_values;
    logic       window_active;
    logic       update_commit;
  } mmc_cal_s;

endpackage

// file: mmc_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - A 16-bit read/write mode register sits at index 0x000 and its bits 8 to 10 read as zero.
// - Mode bits 3 to 5 each include one phase in energy accumulation and pulse output when set.
// - Mode bit 2 set accumulates positive energy only; clear subtracts negative energy.
// - Mode bit 1 set selects single-point phase correction; clear is reserved.
// - Mode bit 0 enables the no-load no_load_threshold_enable threshold.
// - The apparent, active and gain mode fields are stored but steer nothing.
// - Status register at index 0x004 shows the raw phase-A power sign in bit 2, rest zero.
// - Calibration control at index 0x008 has a mode bit 0 that acts at once.
// - In calibration mode, setting update bit 1 opens the window at the next line cycle; updates start at the line cycle after it.
// - After the window the update bit clears itself and updates freeze until restarted.
// - In calibration mode results are computed without calibration values.
// - Calibration mode and update bits reset to zero; bits 2 to 15 read as zero.
// - The window register is a power-of-two exponent 0..8, applied only at window start.
module mmc_regs
  import mmc_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic [mmc_pkg::MMC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [mmc_pkg::MMC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       line_cycle_pulse,
  input  wire logic                       raw_active_power_a_sign,
  output mmc_pkg::mmc_mode_s              mode_out,
  output mmc_pkg::mmc_cal_s               cal_out,
  output logic                            irq
);
  import mmc_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  function automatic logic [11:0] to_index(input logic [MMC_ADDR_W-1:0] a);
    return a[MMC_ADDR_W-1:2];
  endfunction

  // Write and read channel holding registers
  logic [MMC_ADDR_W-1:0] aw_addr_q;
  logic                  aw_have_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  logic                  w_have_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  logic [15:0]           mode_q;
  logic                  cal_mode_q;
  logic                  cal_update_q;
  logic [15:0]           win_reg_q;
  logic [3:0]            win_exp_q;
  logic [MMC_CNT_W-1:0]  win_cnt_q;
  mmc_win_e              win_state_q;
  logic                  neg_q;
  logic [MMC_IRQ_W-1:0]  irq_stat_q;
  logic [MMC_IRQ_W-1:0]  irq_mask_q;

  logic                  wr_fire;
  logic [11:0]           wr_idx;
  logic                  wr_known;
  logic                  wr_mode;
  logic                  wr_cal;
  logic                  wr_win;
  logic                  wr_istat;
  logic                  wr_imask;
  logic [15:0]           cal_merged;
  logic                  rd_fire;
  logic [11:0]           rd_idx;
  logic [3:0]            win_exp_new;
  logic                  win_last;
  logic                  win_done;
  logic [MMC_IRQ_W-1:0]  irq_set;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign wr_fire    = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx     = to_index(aw_addr_q);
  assign wr_mode    = wr_fire && (wr_idx == MMC_IDX_MODE);
  assign wr_cal     = wr_fire && (wr_idx == MMC_IDX_CAL);
  assign wr_win     = wr_fire && (wr_idx == MMC_IDX_WINDOW);
  assign wr_istat   = wr_fire && (wr_idx == MMC_IDX_IRQ_STAT);
  assign wr_imask   = wr_fire && (wr_idx == MMC_IDX_IRQ_MASK);
  assign wr_known   = (wr_idx == MMC_IDX_MODE) || (wr_idx == MMC_IDX_CAL) ||
                      (wr_idx == MMC_IDX_WINDOW) || (wr_idx == MMC_IDX_IRQ_STAT) ||
                      (wr_idx == MMC_IDX_IRQ_MASK) || (wr_idx == MMC_IDX_STATUS);
  assign cal_merged = merge16({14'h0000, cal_update_q, cal_mode_q}, w_data_q, w_strb_q);
  assign rd_fire    = s_axi_arvalid && !rvalid_q;
  assign rd_idx     = to_index(s_axi_araddr);

  // Exponents above the largest window are held at the largest window
  assign win_exp_new = (win_reg_q[3:0] > MMC_WIN_MAX_EXP || win_reg_q[15:4] != 12'h000) ?
                       MMC_WIN_MAX_EXP : win_reg_q[3:0];
  assign win_last    = (win_cnt_q == MMC_CNT_W'((1 << win_exp_q) - 1));
  assign win_done    = (win_state_q == MMC_WIN_RUN) && line_cycle_pulse && win_last &&
                       cal_mode_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= MMC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? MMC_RESP_OKAY : MMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= MMC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= MMC_RESP_OKAY;
      case (rd_idx)
        MMC_IDX_MODE: begin
          rdata_q <= {16'h0000, mode_q};
        end
        MMC_IDX_STATUS: begin
          rdata_q <= 32'(neg_q) << MMC_STAT_NEG;
        end
        MMC_IDX_CAL: begin
          rdata_q <= {30'h0000_0000, cal_update_q, cal_mode_q};
        end
        MMC_IDX_WINDOW: begin
          rdata_q <= {16'h0000, win_reg_q};
        end
        MMC_IDX_IRQ_STAT: begin
          rdata_q <= {30'h0000_0000, irq_stat_q};
        end
        MMC_IDX_IRQ_MASK: begin
          rdata_q <= {30'h0000_0000, irq_mask_q};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= MMC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Reserved bits 8..10 never store, so they read back as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MMC_MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= merge16(mode_q, w_data_q, w_strb_q) & MMC_MODE_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_reg_q <= MMC_WIN_RESET;
    end else if (wr_win) begin
      win_reg_q <= merge16(win_reg_q, w_data_q, w_strb_q);
    end
  end

  // Calibration control; the window state machine owns the update bit's clearing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_mode_q   <= 1'b0;
      cal_update_q <= 1'b0;
    end else if (wr_cal) begin
      cal_mode_q   <= cal_merged[MMC_CAL_MODE];
      // Update only sticks when calibration mode is on after this write
      cal_update_q <= cal_merged[MMC_CAL_UPDATE] && cal_merged[MMC_CAL_MODE];
    end else if (win_done) begin
      cal_update_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_state_q <= MMC_WIN_IDLE;
      win_cnt_q   <= '0;
      win_exp_q   <= 4'h0;
    end else if (!cal_mode_q || !cal_update_q) begin
      win_state_q <= MMC_WIN_IDLE;
      win_cnt_q   <= '0;
    end else begin
      case (win_state_q)
        MMC_WIN_IDLE: begin
          win_state_q <= MMC_WIN_ARMED;
        end
        MMC_WIN_ARMED: begin
          if (line_cycle_pulse) begin
            win_state_q <= MMC_WIN_RUN;
            win_cnt_q   <= '0;
            win_exp_q   <= win_exp_new;
          end
        end
        MMC_WIN_RUN: begin
          if (line_cycle_pulse) begin
            if (win_last) begin
              win_state_q <= MMC_WIN_IDLE;
              win_cnt_q   <= '0;
            end else begin
              win_cnt_q <= win_cnt_q + 1'b1;
            end
          end
        end
        default: begin
          win_state_q <= MMC_WIN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= raw_active_power_a_sign;
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  assign irq_set[MMC_IRQ_DONE] = win_done;
  assign irq_set[MMC_IRQ_NEG]  = raw_active_power_a_sign && !neg_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_istat && w_strb_q[0] ?
                     w_data_q[MMC_IRQ_W-1:0] : '0)) | irq_set;
      if (wr_imask && w_strb_q[0]) begin
        irq_mask_q <= w_data_q[MMC_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb begin
    mode_out.phase_accumulate_enable  = mode_q[MMC_MODE_ENA_LSB +: 3];
    mode_out.positive_only            = mode_q[MMC_MODE_POSONLY];
    mode_out.single_point_phase       = mode_q[MMC_MODE_PHASE];
    mode_out.no_load_threshold_enable = mode_q[MMC_MODE_NOLOAD];
    cal_out.cal_mode                  = cal_mode_q;
    cal_out.use_cal_values            = !cal_mode_q;
    cal_out.window_active             = (win_state_q == MMC_WIN_RUN) && cal_mode_q;
    // Outside calibration every line cycle commits; inside, only counted window cycles
    cal_out.update_commit             = line_cycle_pulse &&
                                        (!cal_mode_q || (win_state_q == MMC_WIN_RUN));
  end

endmodule

// file: mmc_regs_properties.sv
`timescale 1ns/1ps
module mmc_regs_properties
  import mmc_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               line_cycle_pulse,
  input wire mmc_pkg::mmc_mode_s mode_out,
  input wire mmc_pkg::mmc_cal_s  cal_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
    else $error("write got no response");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read got no response");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // Mode only moves as the result of a register write
  a_mode_write: assert property ($changed(mode_out) |-> ##[0:1] s_axi_bvalid)
    else $error("mode changed without write");
  a_use_cal: assert property (cal_out.use_cal_values == !cal_out.cal_mode)
    else $error("calibration values used in calibration mode");
  a_commit_free: assert property (line_cycle_pulse && !cal_out.cal_mode
    |-> cal_out.update_commit) else $error("normal update missed");
  a_commit_freeze: assert property (cal_out.cal_mode && !cal_out.window_active
    |-> !cal_out.update_commit) else $error("update outside window");
  a_abort_window: assert property ($fell(cal_out.cal_mode)
    |-> ##[0:1] !cal_out.window_active) else $error("window kept after mode clear");
endmodule

bind mmc_regs mmc_regs_properties u_props (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .line_cycle_pulse(line_cycle_pulse), .mode_out(mode_out),
  .cal_out(cal_out)
);

// file: mmc_regs_test.sv
`timescale 1ns/1ps
module mmc_regs_test;
  import mmc_pkg::*;
  localparam logic [13:0] AD_MODE = {MMC_IDX_MODE, 2'b00};
  localparam logic [13:0] AD_STAT = {MMC_IDX_STATUS, 2'b00};
  localparam logic [13:0] AD_CAL  = {MMC_IDX_CAL, 2'b00};
  localparam logic [13:0] AD_WIN  = {MMC_IDX_WINDOW, 2'b00};
  localparam logic [13:0] AD_IST  = {MMC_IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] AD_MSK  = {MMC_IDX_IRQ_MASK, 2'b00};
  logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, line_cycle_pulse, raw_active_power_a_sign, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  mmc_mode_s   mode_out;
  mmc_cal_s    cal_out;
  int          mismatches, tests_run, c, i;

  mmc_regs dut (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .line_cycle_pulse(line_cycle_pulse), .raw_active_power_a_sign(raw_active_power_a_sign),
    .mode_out(mode_out), .cal_out(cal_out), .irq(irq)
  );

  always #25 clk = ~clk;

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Tasks return at a falling edge so callers compare settled outputs
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf, input logic [1:0] r = MMC_RESP_OKAY);
    logic ta, tw, bv;
    int   n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      if (bv) cmp(32'(s_axi_bresp), 32'(r));
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bv) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) begin
      mismatches++;
      $display("mismatch at %0t: write response timeout", $time);
      final_report();
    end
    @(negedge clk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e,
                    input logic [1:0] r = MMC_RESP_OKAY);
    logic ta, rv;
    int   n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      if (rv) cmp(s_axi_rdata, e);
      if (rv) cmp(32'(s_axi_rresp), 32'(r));
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) begin
      mismatches++;
      $display("mismatch at %0t: read response timeout", $time);
      final_report();
    end
    @(negedge clk);
  endtask

  // One-cycle line pulses with a gap; counts committed cycles in c
  task automatic pl(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      line_cycle_pulse <= 1'b1;
      @(negedge clk);
      if (cal_out.update_commit === 1'b1) c++;
      @(posedge clk);
      line_cycle_pulse <= 1'b0;
      @(negedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    s_axi_awaddr = 14'h0000;
    s_axi_araddr = 14'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    line_cycle_pulse = 1'b0;
    raw_active_power_a_sign = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp(32'(mode_out), 32'h0000_0000);
    cmp(32'(cal_out.use_cal_values), 32'h0000_0001);
    rd(AD_MODE, 32'h0000_0000);
    rd(AD_STAT, 32'h0000_0000);
    rd(AD_CAL, 32'h0000_0000);
    rd(AD_WIN, 32'h0000_0000);
    wr(AD_MODE, 32'hffff_ffff);
    rd(AD_MODE, 32'h0000_f8ff);
    for (i = 0; i < 6; i++) begin
      wr(AD_MODE, 32'h0000_0001 << i);
      cmp(32'(mode_out), 32'h0000_0001 << i);
    end
    wr(AD_MODE, 32'h0000_ffff, 4'h2);
    rd(AD_MODE, 32'h0000_f820);
    wr(14'h0004, 32'h0000_ffff, 4'hf, MMC_RESP_SLVERR);
    rd(14'h0004, 32'h0000_0000, MMC_RESP_SLVERR);
    @(posedge clk);
    raw_active_power_a_sign <= 1'b1;
    repeat (3) @(negedge clk);
    rd(AD_STAT, 32'h0000_0004);
    wr(AD_STAT, 32'h0000_ffff);
    rd(AD_STAT, 32'h0000_0004);
    cmp(32'(irq), 32'h0000_0000);
    wr(AD_MSK, 32'h0000_0003);
    cmp(32'(irq), 32'h0000_0001);
    rd(AD_IST, 32'h0000_0002);
    wr(AD_IST, 32'h0000_0002);
    cmp(32'(irq), 32'h0000_0000);
    @(posedge clk);
    raw_active_power_a_sign <= 1'b0;
    repeat (3) @(negedge clk);
    rd(AD_STAT, 32'h0000_0000);
    wr(AD_CAL, 32'h0000_0006);
    rd(AD_CAL, 32'h0000_0000);
    pl(1);
    cmp(32'(c), 32'h0000_0001);
    wr(AD_CAL, 32'h0000_0001);
    cmp(32'(cal_out.use_cal_values), 32'h0000_0000);
    cmp(32'(cal_out.cal_mode), 32'h0000_0001);
    pl(1);
    cmp(32'(c), 32'h0000_0000);
    wr(AD_WIN, 32'h0000_0001);
    wr(AD_CAL, 32'h0000_0003);
    pl(2);
    cmp(32'(c), 32'h0000_0001);
    wr(AD_WIN, 32'h0000_0003);
    pl(3);
    cmp(32'(c), 32'h0000_0001);
    rd(AD_CAL, 32'h0000_0001);
    rd(AD_IST, 32'h0000_0001);
    wr(AD_IST, 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000);
    wr(AD_CAL, 32'h0000_0003);
    pl(10);
    cmp(32'(c), 32'h0000_0008);
    wr(AD_CAL, 32'h0000_0003);
    pl(2);
    wr(AD_CAL, 32'h0000_0000);
    cmp(32'(cal_out.window_active), 32'h0000_0000);
    pl(1);
    cmp(32'(c), 32'h0000_0001);
    wr(AD_IST, 32'h0000_0001);
    cmp(32'(irq), 32'h0000_0000);
    // Software side of a calibration run: arm, then poll until the update bit drops
    wr(AD_CAL, 32'h0000_0001);
    wr(AD_CAL, 32'h0000_0003);
    for (i = 0; i < 10; i++) begin
      rd(AD_CAL, (i < 9) ? 32'h0000_0003 : 32'h0000_0001);
      pl(1);
    end
    cmp(32'(irq), 32'h0000_0001);
    // Out-of-range exponent is held at the largest window
    wr(AD_WIN, 32'h0000_000f);
    wr(AD_CAL, 32'h0000_0003);
    pl(258);
    cmp(32'(c), 32'h0000_0100);
    final_report();
  end
endmodule
